// >>> src/cdr_regs.sv
// CPU dedicated registers, condition codes and bank addressing
//
// The register offsets and the plain strobed port were decided locally.
`default_nettype none
// Contract
// RL1: Sixteen-bit program counter of fetched instruction
// RL2: Sixteen-bit accumulator, byte ops use low byte
// RL3: Sixteen-bit temporary second operand, low byte
// RL4: Sixteen-bit index, extra and stack pointers
// RL5: Status word: bank pointer high, codes low
// RL6: Half carry from bit three to four
// RL7: Interrupt enable gates interrupts, reset clears
// RL8: Service only requests above stored level
// RL9: Negative flag copies result top bit
// RL10: Zero flag set on zero result
// RL11: Overflow flag on two's complement overflow
// RL12: Carry flag on carry out of bit seven
// RL13: Shifts load carry with shifted-out bit
// RL14: Byte registers in memory, 32 banks of eight
// RL15: Bank pointer selects active register bank
// RL16: 64K space, I/O lowest, data above
// RL17: Register address is base, bank, number
module cdr_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire cdr_pkg::cdr_bus_t bus,
   output logic [15:0] rdata,
   // Arithmetic requests
   input wire cdr_pkg::cdr_alu_req_t alu,
   input wire logic pc_inc,
   // Interrupt requests
   input wire logic irq_req,
   input wire logic [1:0] irq_lvl,
   output logic irq_take,
   // Memory addressing
   input wire logic [2:0] gpr_num,
   input wire logic [15:0] probe_addr,
   output logic [15:0] gpr_addr,
   output logic addr_is_io
);
   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] pc_reg; // Program counter
   logic [15:0] acc_reg; // Accumulator
   logic [15:0] tmp_reg; // Temporary accumulator
   logic [15:0] idx_reg; // Index register
   logic [15:0] ext_reg; // Extra pointer
   logic [15:0] stk_reg; // Stack pointer
   logic [7:0] bank_reg; // Bank pointer
   logic [7:0] ccr_reg; // Condition codes
   logic [15:0] rdata_reg; // Read data
   logic irq_take_reg; // Interrupt accepted
   logic [15:0] gpr_addr_reg; // Register address
   logic io_reg; // Probe in I/O area

   // ****************************************
   // Decode
   // ****************************************
   logic [15:0] prog_status_word; // Status word view
   logic wr_pc, wr_acc, wr_tmp, wr_psw; // Write selects
   logic [15:0] res; // Operation result
   logic c_new, v_new, h_new, n_new, z_new; // New flags
   logic [16:0] add17, sub17; // Full width sums
   logic [8:0] add9, sub9; // Byte sums
   logic [4:0] add5, sub5; // Nibble sums

   assign prog_status_word = {bank_reg, ccr_reg}; // [RL5]
   assign wr_pc = bus.wr && bus.addr == cdr_pkg::OFF_PC;
   assign wr_acc = bus.wr && bus.addr == cdr_pkg::OFF_ACC;
   assign wr_tmp = bus.wr && bus.addr == cdr_pkg::OFF_TMP;
   assign wr_psw = bus.wr && bus.addr == cdr_pkg::OFF_PSW;

   // ****************************************
   // Arithmetic
   // ****************************************
   assign add17 = {1'b0, acc_reg} + {1'b0, tmp_reg};
   assign sub17 = {1'b0, acc_reg} - {1'b0, tmp_reg};
   assign add9 = {1'b0, acc_reg[7:0]} + {1'b0, tmp_reg[7:0]};
   assign sub9 = {1'b0, acc_reg[7:0]} - {1'b0, tmp_reg[7:0]};
   assign add5 = {1'b0, acc_reg[3:0]} + {1'b0, tmp_reg[3:0]};
   assign sub5 = {1'b0, acc_reg[3:0]} - {1'b0, tmp_reg[3:0]};

   // Result and flags of the requested operation
   always_comb begin
      res = acc_reg;
      c_new = ccr_reg[cdr_pkg::CC_C];
      v_new = ccr_reg[cdr_pkg::CC_V];
      h_new = ccr_reg[cdr_pkg::CC_H];
      case (alu.op)
         cdr_pkg::ALU_ADD: begin
            h_new = add5[4]; // [RL6]
            if (alu.wide) begin
               res = add17[15:0];
               c_new = add17[16];
               v_new = (acc_reg[15] == tmp_reg[15]) && (res[15] != acc_reg[15]);
            end else begin
               // Byte op keeps the high byte
               res = {acc_reg[15:8], add9[7:0]}; // [RL2] [RL3]
               c_new = add9[8]; // [RL12]
               v_new = (acc_reg[7] == tmp_reg[7]) && (res[7] != acc_reg[7]); // [RL11]
            end
         end
         cdr_pkg::ALU_SUB: begin
            h_new = sub5[4]; // [RL6]
            if (alu.wide) begin
               res = sub17[15:0];
               c_new = sub17[16];
               v_new = (acc_reg[15] != tmp_reg[15]) && (res[15] != acc_reg[15]);
            end else begin
               res = {acc_reg[15:8], sub9[7:0]}; // [RL2]
               c_new = sub9[8]; // [RL12]
               v_new = (acc_reg[7] != tmp_reg[7]) && (res[7] != acc_reg[7]); // [RL11]
            end
         end
         cdr_pkg::ALU_SHL: begin
            // Carry takes the bit pushed out
            if (alu.wide) begin
               res = {acc_reg[14:0], 1'b0};
               c_new = acc_reg[15]; // [RL13]
            end else begin
               res = {acc_reg[15:8], acc_reg[6:0], 1'b0};
               c_new = acc_reg[7]; // [RL13]
            end
         end
         cdr_pkg::ALU_SHR: begin
            c_new = acc_reg[0]; // [RL13]
            if (alu.wide) begin
               res = {1'b0, acc_reg[15:1]};
            end else begin
               res = {acc_reg[15:8], 1'b0, acc_reg[7:1]};
            end
         end
         default: begin
            res = acc_reg;
         end
      endcase
      n_new = alu.wide ? res[15] : res[7]; // [RL9]
      z_new = alu.wide ? (res == 16'h0000) : (res[7:0] == 8'h00); // [RL10]
   end

   // ****************************************
   // Program counter
   // ****************************************
   // Bus write wins over increment
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= cdr_pkg::RST_WORD;
      end else if (wr_pc) begin
         pc_reg <= bus.wdata;
      end else if (pc_inc) begin
         pc_reg <= pc_reg + 16'h0001; // [RL1]
      end
   end

   // ****************************************
   // Accumulator
   // ****************************************
   // Operation result wins over bus write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= cdr_pkg::RST_WORD;
      end else if (alu.go) begin
         acc_reg <= res; // [RL2]
      end else if (wr_acc) begin
         acc_reg <= bus.wdata;
      end
   end

   // ****************************************
   // Temporary accumulator
   // ****************************************
   // Second operand, loaded by software only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmp_reg <= cdr_pkg::RST_WORD;
      end else if (wr_tmp) begin
         tmp_reg <= bus.wdata; // [RL3]
      end
   end

   // ****************************************
   // Pointers
   // ****************************************
   // Index, extra and stack pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_reg <= cdr_pkg::RST_WORD;
         ext_reg <= cdr_pkg::RST_WORD;
         stk_reg <= cdr_pkg::RST_WORD;
      end else if (bus.wr) begin
         case (bus.addr)
            cdr_pkg::OFF_IDX: idx_reg <= bus.wdata; // [RL4]
            cdr_pkg::OFF_EXT: ext_reg <= bus.wdata; // [RL4]
            cdr_pkg::OFF_STK: stk_reg <= bus.wdata; // [RL4]
            default: begin
               idx_reg <= idx_reg;
            end
         endcase
      end
   end

   // ****************************************
   // Status word
   // ****************************************
   // Bank pointer from the high byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_reg <= cdr_pkg::RST_BANK;
      end else if (wr_psw) begin
         bank_reg <= bus.wdata[15:8]; // [RL5]
      end
   end

   // Condition codes, flag updates win over a write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ccr_reg <= cdr_pkg::RST_CCR; // [RL7]
      end else begin
         if (wr_psw) begin
            ccr_reg <= bus.wdata[7:0]; // [RL5]
         end
         if (alu.go) begin
            ccr_reg[cdr_pkg::CC_H] <= h_new; // [RL6]
            ccr_reg[cdr_pkg::CC_N] <= n_new; // [RL9]
            ccr_reg[cdr_pkg::CC_Z] <= z_new; // [RL10]
            ccr_reg[cdr_pkg::CC_V] <= v_new; // [RL11]
            ccr_reg[cdr_pkg::CC_C] <= c_new; // [RL12]
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // Data in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= cdr_pkg::RST_WORD;
      end else if (bus.rd) begin
         case (bus.addr)
            cdr_pkg::OFF_PC: rdata_reg <= pc_reg;
            cdr_pkg::OFF_ACC: rdata_reg <= acc_reg;
            cdr_pkg::OFF_TMP: rdata_reg <= tmp_reg;
            cdr_pkg::OFF_IDX: rdata_reg <= idx_reg;
            cdr_pkg::OFF_EXT: rdata_reg <= ext_reg;
            cdr_pkg::OFF_STK: rdata_reg <= stk_reg;
            cdr_pkg::OFF_PSW: rdata_reg <= prog_status_word; // [RL5]
            default: rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   // ****************************************
   // Interrupt acceptance
   // ****************************************
   // Lower number ranks higher
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_reg <= 1'b0;
      end else begin
         irq_take_reg <= irq_req && ccr_reg[cdr_pkg::CC_I] // [RL7]
            && (irq_lvl < ccr_reg[cdr_pkg::CC_IRQ_LEVEL_HI:cdr_pkg::CC_IRQ_LEVEL_LO]); // [RL8]
      end
   end

   // ****************************************
   // Memory addressing
   // ****************************************
   // Bank register address and area check
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpr_addr_reg <= cdr_pkg::RST_WORD;
         io_reg <= 1'b0;
      end else begin
         gpr_addr_reg <= {cdr_pkg::GPR_BASE, bank_reg[4:0], gpr_num}; // [RL14] [RL15] [RL17]
         io_reg <= probe_addr < cdr_pkg::IO_END; // [RL16]
      end
   end

   assign rdata = rdata_reg;
   assign irq_take = irq_take_reg;
   assign gpr_addr = gpr_addr_reg;
   assign addr_is_io = io_reg;

   // ****************************************
   // Checks
   // ****************************************
   property p_pc_inc;
      @(posedge clk) disable iff (!rst_n)
      pc_inc && !wr_pc |=> pc_reg == $past(pc_reg) + 16'h0001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc not incremented"); // [RL1]

   property p_acc_high;
      @(posedge clk) disable iff (!rst_n)
      alu.go && !alu.wide |=> acc_reg[15:8] == $past(acc_reg[15:8]);
   endproperty
   a_acc_high: assert property (p_acc_high) else $error("byte op changed high"); // [RL2]

   property p_tmp_hold;
      @(posedge clk) disable iff (!rst_n)
      alu.go && !wr_tmp |=> $stable(tmp_reg);
   endproperty
   a_tmp_hold: assert property (p_tmp_hold) else $error("operand changed"); // [RL3]

   property p_psw_read;
      @(posedge clk) disable iff (!rst_n)
      bus.rd && bus.addr == cdr_pkg::OFF_PSW |=> rdata == $past(prog_status_word);
   endproperty
   a_psw_read: assert property (p_psw_read) else $error("status read wrong"); // [RL5]

   property p_half;
      @(posedge clk) disable iff (!rst_n)
      alu.go && alu.op == cdr_pkg::ALU_ADD
      |=> ccr_reg[cdr_pkg::CC_H] == $past(add5[4]);
   endproperty
   a_half: assert property (p_half) else $error("half carry wrong"); // [RL6]

   property p_neg;
      @(posedge clk) disable iff (!rst_n)
      alu.go |=> ccr_reg[cdr_pkg::CC_N] == ($past(alu.wide) ? acc_reg[15] : acc_reg[7]);
   endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong"); // [RL9]

   property p_zero;
      @(posedge clk) disable iff (!rst_n)
      alu.go && !alu.wide |=> ccr_reg[cdr_pkg::CC_Z] == (acc_reg[7:0] == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RL10]

   property p_shl_c;
      @(posedge clk) disable iff (!rst_n)
      alu.go && !alu.wide && alu.op == cdr_pkg::ALU_SHL
      |=> ccr_reg[cdr_pkg::CC_C] == $past(acc_reg[7]);
   endproperty
   a_shl_c: assert property (p_shl_c) else $error("shift carry wrong"); // [RL13]

   property p_ie_block;
      @(posedge clk) disable iff (!rst_n)
      !ccr_reg[cdr_pkg::CC_I] |=> !irq_take;
   endproperty
   a_ie_block: assert property (p_ie_block) else $error("taken while disabled"); // [RL7]

   property p_level;
      @(posedge clk) disable iff (!rst_n)
      irq_req && ccr_reg[cdr_pkg::CC_I] && irq_lvl >= ccr_reg[5:4] |=> !irq_take;
   endproperty
   a_level: assert property (p_level) else $error("low level taken"); // [RL8]

   property p_gpr;
      @(posedge clk) disable iff (!rst_n)
      // Start only once reset was seen released, the flop holds zero at the release edge
      rst_n |=> gpr_addr[7:3] == $past(bank_reg[4:0]) && gpr_addr[2:0] == $past(gpr_num);
   endproperty
   a_gpr: assert property (p_gpr) else $error("bank address wrong"); // [RL15]

   c_take: cover property (@(posedge clk) disable iff (!rst_n) irq_take);
   c_carry: cover property (@(posedge clk) disable iff (!rst_n)
      alu.go ##1 ccr_reg[cdr_pkg::CC_C]);
   c_ovf: cover property (@(posedge clk) disable iff (!rst_n)
      alu.go ##1 ccr_reg[cdr_pkg::CC_V]);
endmodule : cdr_regs
`default_nettype wire

// >>> src/cdr_pkg.sv
// Package of constants and types for the CPU dedicated register block
`default_nettype none
package cdr_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int unsigned WORD_W = 16; // Dedicated register width
   localparam int unsigned ADDR_W = 3; // Register port address width
   localparam int unsigned GPR_W = 3; // Register number within a bank
   localparam int unsigned BANK_W = 5; // Bank bits, 32 banks

   // ****************************************
   // Register port offsets
   // ****************************************
   localparam logic [2:0] OFF_PC = 3'h0; // Program counter
   localparam logic [2:0] OFF_ACC = 3'h1; // Accumulator
   localparam logic [2:0] OFF_TMP = 3'h2; // Temporary accumulator
   localparam logic [2:0] OFF_IDX = 3'h3; // Index register
   localparam logic [2:0] OFF_EXT = 3'h4; // Extra pointer
   localparam logic [2:0] OFF_STK = 3'h5; // Stack pointer
   localparam logic [2:0] OFF_PSW = 3'h6; // Program status word

   // ****************************************
   // Condition code bit positions
   // ****************************************
   localparam int unsigned CC_H = 7; // Half carry
   localparam int unsigned CC_I = 6; // Interrupt enable
   localparam int unsigned CC_IRQ_LEVEL_HI = 5; // Level high bit
   localparam int unsigned CC_IRQ_LEVEL_LO = 4; // Level low bit
   localparam int unsigned CC_N = 3; // Negative
   localparam int unsigned CC_Z = 2; // Zero
   localparam int unsigned CC_V = 1; // Overflow
   localparam int unsigned CC_C = 0; // Carry

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] RST_WORD = 16'h0000; // Pointers and data
   localparam logic [7:0] RST_BANK = 8'h00; // Bank pointer
   localparam logic [7:0] RST_CCR = 8'h30; // Interrupts off, lowest level

   // ****************************************
   // Memory layout
   // ****************************************
   localparam logic [7:0] GPR_BASE = 8'h01; // Upper bits of bank area
   localparam logic [15:0] IO_END = 16'h0080; // First address above I/O

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ALU_ADD = 2'b00, // Add temporary to accumulator
      ALU_SUB = 2'b01, // Subtract temporary from accumulator
      ALU_SHL = 2'b10, // Shift accumulator left
      ALU_SHR = 2'b11 // Shift accumulator right
   } cdr_alu_op_t;

   typedef struct packed {
      logic go; // One-cycle operation strobe
      logic wide; // 1: 16-bit, 0: 8-bit
      cdr_alu_op_t op; // Operation
   } cdr_alu_req_t;

   typedef struct packed {
      logic wr; // Write strobe
      logic rd; // Read strobe
      logic [2:0] addr; // Register offset
      logic [15:0] wdata; // Write data
   } cdr_bus_t;
endpackage : cdr_pkg
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the CPU dedicated register block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals and bookkeeping
   // ****************************************
   logic clk; // Core clock
   logic rst_n; // Active-low reset
   cdr_pkg::cdr_bus_t bus; // Register port request
   logic [15:0] rdata; // Register read data
   cdr_pkg::cdr_alu_req_t alu; // Arithmetic request
   logic pc_inc; // Program counter step
   logic irq_req; // Interrupt request
   logic [1:0] irq_lvl; // Request level
   logic irq_take; // Request accepted
   logic [2:0] gpr_num; // Register number in bank
   logic [15:0] probe_addr; // Address to classify
   logic [15:0] gpr_addr; // Register memory address
   logic addr_is_io; // Probe lies in I/O area
   int error_cnt; // Mismatches seen
   int comparisons; // Checks made
   logic [15:0] got; // Read-back value

   // One arithmetic case: operands, result, whole condition code byte
   typedef struct packed {
      cdr_pkg::cdr_alu_op_t op;
      logic wide;
      logic [15:0] acc;
      logic [15:0] tmp;
      logic [15:0] res;
      logic [7:0] cond_code_reg;
   } cdr_alu_row_t;

   // Codes preset to 8'h82 (half carry and overflow set) before each case
   cdr_alu_row_t rows [12] = '{
      '{cdr_pkg::ALU_ADD, 1'b0, 16'h127f, 16'h0001, 16'h1280, 8'h8a},
      '{cdr_pkg::ALU_ADD, 1'b0, 16'h00ff, 16'h0001, 16'h0000, 8'h85},
      '{cdr_pkg::ALU_SUB, 1'b0, 16'h0010, 16'h0001, 16'h000f, 8'h80},
      '{cdr_pkg::ALU_SUB, 1'b0, 16'h0000, 16'h0001, 16'h00ff, 8'h89},
      '{cdr_pkg::ALU_SUB, 1'b0, 16'h0080, 16'h0001, 16'h007f, 8'h82},
      '{cdr_pkg::ALU_ADD, 1'b1, 16'h7fff, 16'h0001, 16'h8000, 8'h8a},
      '{cdr_pkg::ALU_ADD, 1'b1, 16'hffff, 16'h0001, 16'h0000, 8'h85},
      '{cdr_pkg::ALU_SUB, 1'b1, 16'h0000, 16'h0001, 16'hffff, 8'h89},
      '{cdr_pkg::ALU_SHL, 1'b0, 16'h1281, 16'hffff, 16'h1202, 8'h83},
      '{cdr_pkg::ALU_SHR, 1'b0, 16'h0001, 16'hffff, 16'h0000, 8'h87},
      '{cdr_pkg::ALU_SHL, 1'b1, 16'h8000, 16'hffff, 16'h0000, 8'h87},
      '{cdr_pkg::ALU_SHL, 1'b1, 16'h4000, 16'hffff, 16'h8000, 8'h8a}
   };

   // ****************************************
   // Clock and design
   // ****************************************
   always #5 clk = ~clk;

   cdr_regs DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .alu(alu),
      .pc_inc(pc_inc), .irq_req(irq_req), .irq_lvl(irq_lvl), .irq_take(irq_take),
      .gpr_num(gpr_num), .probe_addr(probe_addr), .gpr_addr(gpr_addr),
      .addr_is_io(addr_is_io));

   // ****************************************
   // Helper tasks
   // ****************************************
   // Compare and count
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : check

   // One-cycle register write
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : reg_wr

   // One-cycle read, data taken in the following cycle
   task automatic rd_chk(input logic [2:0] a, input logic [15:0] e, input string m);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      check(rdata, e, m);
   endtask : rd_chk

   // One arithmetic strobe
   task automatic alu_go(input cdr_pkg::cdr_alu_op_t op, input logic wide);
      @(posedge clk);
      alu <= '{go: 1'b1, wide: wide, op: op};
      @(posedge clk);
      alu.go <= 1'b0;
   endtask : alu_go

   // Verdict and end of run
   task automatic conclude;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus = '0;
      alu = '0;
      pc_inc = 1'b0;
      irq_req = 1'b0;
      irq_lvl = 2'h0;
      gpr_num = 3'h0;
      probe_addr = 16'h0000;
      error_cnt = 0;
      comparisons = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Arithmetic table
      foreach (rows[i]) begin
         reg_wr(cdr_pkg::OFF_PSW, 16'h0082);
         reg_wr(cdr_pkg::OFF_TMP, rows[i].tmp);
         reg_wr(cdr_pkg::OFF_ACC, rows[i].acc);
         alu_go(rows[i].op, rows[i].wide);
         rd_chk(cdr_pkg::OFF_ACC, rows[i].res, "alu result");
         rd_chk(cdr_pkg::OFF_PSW, {8'h00, rows[i].cond_code_reg}, "alu codes");
      end
      $display("test alu table done");
      // Reset values, then interrupt refused while disabled
      for (int k = 0; k < 8; k++) begin
         if (k == 0) begin
            @(posedge clk);
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
         end
         rd_chk(3'(k), (k == 6) ? 16'h0030 : 16'h0000, "reset value");
      end
      @(posedge clk);
      irq_req <= 1'b1;
      irq_lvl <= 2'h0;
      @(posedge clk);
      #1;
      check({15'h0000, irq_take}, 16'h0000, "take while disabled");
      @(posedge clk);
      irq_req <= 1'b0;
      $display("test reset done");
      // Write and read back every offset, unmapped one reads zero
      for (int k = 0; k < 8; k++) begin
         reg_wr(3'(k), 16'hc3a0 | 16'(k));
         rd_chk(3'(k), (k == 7) ? 16'h0000 : (16'hc3a0 | 16'(k)), "read back");
      end
      @(posedge clk);
      #1;
      check(rdata, 16'h0000, "read data idle");
      $display("test registers done");
      // Counter wrap, then write beating step
      reg_wr(cdr_pkg::OFF_PC, 16'hfffe);
      @(posedge clk);
      pc_inc <= 1'b1;
      repeat (2) @(posedge clk);
      pc_inc <= 1'b0;
      rd_chk(cdr_pkg::OFF_PC, 16'h0000, "counter wrap");
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: cdr_pkg::OFF_PC, wdata: 16'h1234};
      pc_inc <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      pc_inc <= 1'b0;
      rd_chk(cdr_pkg::OFF_PC, 16'h1234, "counter write");
      $display("test counter done");
      // Every stored level against every request level
      for (int il = 0; il < 4; il++) begin
         reg_wr(cdr_pkg::OFF_PSW, {8'h00, 2'b01, 2'(il), 4'h0});
         for (int l = 0; l < 4; l++) begin
            @(posedge clk);
            irq_req <= 1'b1;
            irq_lvl <= 2'(l);
            @(posedge clk);
            #1;
            check({15'h0000, irq_take}, (l < il) ? 16'h0001 : 16'h0000, "level");
         end
         @(posedge clk);
         irq_req <= 1'b0;
      end
      $display("test interrupt done");
      // Bank addressing, upper pointer bits ignored
      for (int b = 0; b < 32; b += 7) begin
         reg_wr(cdr_pkg::OFF_PSW, {3'b101, 5'(b), 8'h00});
         @(posedge clk);
         gpr_num <= 3'(b) ^ 3'h5;
         @(posedge clk);
         #1;
         check(gpr_addr, {8'h01, 5'(b), 3'(b) ^ 3'h5}, "bank address");
      end
      $display("test bank done");
      // I/O area boundary
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         probe_addr <= (k == 0) ? 16'h0000 : (k == 1) ? 16'h007f : (k == 2) ? 16'h0080 : 16'hffff;
         @(posedge clk);
         #1;
         check({15'h0000, addr_is_io}, (k < 2) ? 16'h0001 : 16'h0000, "io area");
      end
      $display("test io area done");
      // Reset in mid-run clears enable and data
      reg_wr(cdr_pkg::OFF_ACC, 16'hbeef);
      reg_wr(cdr_pkg::OFF_PSW, 16'h0740);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(cdr_pkg::OFF_ACC, 16'h0000, "second reset data");
      rd_chk(cdr_pkg::OFF_PSW, 16'h0030, "second reset codes");
      $display("test second reset done");
      conclude();
   end
endmodule : tb
`default_nettype wire
